// File: pkg/pwrseq_pkg.sv
// Constants shared by the pushbutton power sequencer
`default_nettype none
package pwrseq_pkg;
   // Timebase
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned CYC_PER_MS  = CLK_HZ / 1000;
   localparam int unsigned DEB_MS      = 32;
   localparam int unsigned BLANK_MS    = 512;
   localparam int unsigned LOCK_MS     = 1000;
   localparam int unsigned DEB_CYC     = DEB_MS * CYC_PER_MS;
   localparam int unsigned BLANK_CYC   = BLANK_MS * CYC_PER_MS;
   localparam int unsigned LOCK_CYC    = LOCK_MS * CYC_PER_MS;
   localparam int unsigned TMR_STEPS   = 16;
   localparam logic [3:0]  TMR_STEP_SH = 4'h4;          // 16 steps as a shift
   // Register byte offsets
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  TSTEP_OFS   = 8'h04;
   localparam logic [7:0]  STATUS_OFS  = 8'h08;
   // Timer pin modes (control bits 1:0)
   localparam logic [1:0]  TMR_OPEN    = 2'h0;
   localparam logic [1:0]  TMR_CAP     = 2'h1;
   localparam logic [1:0]  TMR_GND     = 2'h2;
   // Reset values
   localparam logic [1:0]  CTRL_RST    = TMR_OPEN;
   localparam logic [31:0] TSTEP_RST   = 32'h00008c61;  // Cycles per timer step
   // Status field positions
   localparam int unsigned ST_EN       = 0;
   localparam int unsigned ST_REQ_N    = 1;
   localparam int unsigned ST_GOOD     = 2;
   localparam int unsigned ST_SRC_MON  = 3;
   localparam int unsigned ST_STATE    = 4;

   typedef enum logic [3:0] {
      S_WAIT, S_ON_DEB, S_BLANK, S_ON_RUN, S_OFF_DEB, S_REQ_MIN, S_TMR_RUN, S_OFF_HOLD, S_LOCKOUT
   } seq_state_t;
endpackage : pwrseq_pkg
`default_nettype wire

// File: rtl/pwrseq.sv
// Pushbutton and supply-monitor power sequencer with APB control
`timescale 1ns/1ps
`default_nettype none
module pwrseq
   import pwrseq_pkg::*;
#(
   parameter logic [31:0] DEB_CYCLES   = DEB_CYC,
   parameter logic [31:0] BLANK_CYCLES = BLANK_CYC,
   parameter logic [31:0] LOCK_CYCLES  = LOCK_CYC,
   parameter bit          EN_ACT_LOW   = 1'b0
) (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic        CE,
   input  wire logic        BUTTON_N,
   input  wire logic        MONITOR,
   input  wire logic        KILL_N,
   input  wire logic        MODE_SEL,
   output logic             POWER_EN,
   output logic             SHUTDOWN_REQ_N,
   output logic             SENSE_GOOD,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);
   // Counts below two would skip the compare-to-last checks
   if (DEB_CYCLES < 32'h2 || BLANK_CYCLES < 32'h2 || LOCK_CYCLES < 32'h2) begin : gen_cnt_chk
      $error("pwrseq: interval counts must be at least 2");
   end

   logic [3:0]  sync1_r;
   logic [3:0]  sync2_r;
   logic        btn_s;
   logic        mon_s;
   logic        kill_s;
   logic        sel_s;
   logic        mon_prev_r;
   logic        btn_prev_r;
   seq_state_t  state_r;
   logic [31:0] cnt_r;
   logic        src_mon_r;
   logic        off_mon_r;
   logic        ign_btn_r;
   logic        en_pin_r;
   logic        req_n_r;
   logic        good_r;
   logic [1:0]  tmr_mode_r;
   logic [31:0] tstep_r;
   logic        en_on;
   logic        mon_rise;
   logic        mon_fall;
   logic        btn_fall;
   logic        trig_low;
   logic [31:0] tmr_last;

   // Two-stage synchronisers for the button, monitor, kill and mode-select pins
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sync1_r <= 4'hd;                                         // Monitor low, no false sense-good
         sync2_r <= 4'hd;
      end else if (CE) begin
         sync1_r <= {MODE_SEL, KILL_N, MONITOR, BUTTON_N};
         sync2_r <= sync1_r;
      end
   end

   assign btn_s  = sync2_r[0];
   assign mon_s  = sync2_r[1];
   assign kill_s = sync2_r[2];
   assign sel_s  = sync2_r[3];

   // Previous samples for edge detection
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         mon_prev_r <= 1'b0;
         btn_prev_r <= 1'b1;
      end else if (CE) begin
         mon_prev_r <= mon_s;
         btn_prev_r <= btn_s;
      end
   end

   assign en_on    = en_pin_r ^ EN_ACT_LOW;
   assign mon_rise = mon_s && !mon_prev_r;
   assign mon_fall = !mon_s && mon_prev_r;
   assign btn_fall = !btn_s && btn_prev_r;
   assign trig_low = off_mon_r ? !mon_s : !btn_s;
   assign tmr_last = (tstep_r << TMR_STEP_SH) - 32'h1;           // 16 steps

   // Main power sequence
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_r   <= S_LOCKOUT;
         cnt_r     <= 32'h0;
         src_mon_r <= 1'b0;
         off_mon_r <= 1'b0;
         ign_btn_r <= 1'b0;
         en_pin_r  <= EN_ACT_LOW;
         req_n_r   <= 1'b1;
      end else if (CE) begin
         cnt_r <= cnt_r + 32'h1;
         case (state_r)
            S_WAIT: begin
               cnt_r <= 32'h0;
               if (btn_fall) begin
                  state_r   <= S_ON_DEB;
                  src_mon_r <= 1'b0;
               end else if (mon_rise) begin
                  state_r   <= S_ON_DEB;
                  src_mon_r <= 1'b1;
               end
            end
            S_ON_DEB: begin
               if (!src_mon_r && btn_s) begin
                  cnt_r <= 32'h0;
                  if (mon_s) begin
                     src_mon_r <= 1'b1;
                  end else begin
                     state_r <= S_WAIT;
                  end
               end else if (src_mon_r && !mon_s) begin
                  state_r <= S_WAIT;
               end else if (cnt_r == DEB_CYCLES - 32'h1) begin
                  state_r  <= S_BLANK;
                  cnt_r    <= 32'h0;
                  en_pin_r <= !EN_ACT_LOW;
               end
            end
            S_BLANK: begin
               if (cnt_r == BLANK_CYCLES - 32'h1) begin
                  cnt_r     <= 32'h0;
                  ign_btn_r <= !btn_s;
                  if (!kill_s) begin
                     state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                     en_pin_r <= EN_ACT_LOW;
                  end else begin
                     state_r <= S_ON_RUN;
                  end
               end
            end
            S_ON_RUN: begin
               cnt_r <= 32'h0;
               if (btn_s) begin
                  ign_btn_r <= 1'b0;
               end
               if (!kill_s) begin
                  state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                  en_pin_r <= EN_ACT_LOW;
                  req_n_r  <= 1'b1;
               end else if (!btn_s && !ign_btn_r) begin
                  state_r   <= S_OFF_DEB;
                  off_mon_r <= 1'b0;
               end else if (mon_fall && sel_s && src_mon_r) begin
                  state_r   <= S_REQ_MIN;
                  off_mon_r <= 1'b1;
                  req_n_r   <= 1'b0;
               end
            end
            S_OFF_DEB: begin
               if (!kill_s) begin
                  state_r  <= S_OFF_HOLD;
                  en_pin_r <= EN_ACT_LOW;
               end else if (btn_s) begin
                  state_r <= S_ON_RUN;
               end else if (cnt_r == DEB_CYCLES - 32'h1) begin
                  state_r <= S_REQ_MIN;
                  cnt_r   <= 32'h0;
                  req_n_r <= 1'b0;
               end
            end
            S_REQ_MIN: begin
               if (!kill_s) begin
                  state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                  en_pin_r <= EN_ACT_LOW;
                  req_n_r  <= 1'b1;
               end else if (cnt_r >= DEB_CYCLES - 32'h1) begin
                  cnt_r <= cnt_r;
                  if (!trig_low) begin
                     state_r <= S_ON_RUN;
                     req_n_r <= 1'b1;
                  end else if (tmr_mode_r == TMR_GND) begin
                     state_r <= S_REQ_MIN;
                  end else if (tmr_mode_r == TMR_OPEN) begin
                     state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                     en_pin_r <= EN_ACT_LOW;
                     req_n_r  <= 1'b1;
                  end else begin
                     state_r <= S_TMR_RUN;
                     cnt_r   <= 32'h0;
                  end
               end
            end
            S_TMR_RUN: begin
               if (!kill_s) begin
                  state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                  en_pin_r <= EN_ACT_LOW;
                  req_n_r  <= 1'b1;
               end else if (!trig_low) begin
                  state_r <= S_ON_RUN;
                  req_n_r <= 1'b1;
               end else if (cnt_r >= tmr_last) begin
                  state_r  <= btn_s ? S_LOCKOUT : S_OFF_HOLD;
                  en_pin_r <= EN_ACT_LOW;
                  req_n_r  <= 1'b1;
               end
            end
            S_OFF_HOLD: begin
               cnt_r <= 32'h0;
               if (btn_s) begin
                  state_r <= S_LOCKOUT;
               end
            end
            S_LOCKOUT: begin
               if (cnt_r == LOCK_CYCLES - 32'h1) begin
                  state_r <= S_WAIT;
                  cnt_r   <= 32'h0;
               end
            end
            default: begin
               state_r <= S_LOCKOUT;
            end
         endcase
      end
   end

   // Sense-good follows the monitor
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         good_r <= 1'b0;
      end else if (CE) begin
         good_r <= mon_s;
      end
   end

   assign POWER_EN       = en_pin_r;
   assign SHUTDOWN_REQ_N = req_n_r;
   assign SENSE_GOOD     = good_r;

   // APB slave, one wait state per access; read data latched on the wait edge
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA  <= 32'h0;
      end else if (CE) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
         if (PSEL && PENABLE && !PREADY) begin
            PREADY <= 1'b1;
            PRDATA <= 32'h0;
            if (PADDR == CTRL_OFS) begin
               PRDATA <= {30'h0, tmr_mode_r};
            end else if (PADDR == TSTEP_OFS) begin
               PRDATA <= tstep_r;
            end else if (PADDR == STATUS_OFS) begin
               PRDATA <= {24'h0, state_r, src_mon_r, good_r, req_n_r, en_on};
            end else begin
               PSLVERR <= 1'b1;
            end
         end
      end
   end

   // Register writes land on the edge that completes the transfer
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         tmr_mode_r <= CTRL_RST;
         tstep_r    <= TSTEP_RST;
      end else if (CE && PSEL && PENABLE && PREADY && PWRITE) begin
         if (PADDR == CTRL_OFS) begin
            tmr_mode_r <= PWDATA[1:0];
         end else if (PADDR == TSTEP_OFS) begin
            tstep_r <= (PWDATA == 32'h0) ? 32'h1 : PWDATA;   // Zero step would never end
         end
      end
   end

   // Checks on the sequence
   blank_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
      state_r == S_BLANK |-> en_on && req_n_r)
      else $error("enable or request changed during blanking");
   deb_len_a: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(en_on) |-> $past(state_r) == S_ON_DEB && $past(cnt_r) == DEB_CYCLES - 32'h1)
      else $error("enable rose without full debounce");
   req_len_a: assert property (@(posedge CLK) disable iff (!NRST)
      $fell(req_n_r) && !off_mon_r |-> $past(cnt_r) == DEB_CYCLES - 32'h1)
      else $error("button request asserted without full debounce");
   mon_req_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_ON_RUN && kill_s && (btn_s || ign_btn_r) && mon_fall && sel_s && src_mon_r
      |=> !req_n_r && state_r == S_REQ_MIN)
      else $error("monitor fall did not assert request at once");
   sel_block_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_ON_RUN && mon_fall && !sel_s |=> req_n_r)
      else $error("monitor fall acted with mode select low");
   kill_off_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && !kill_s && (state_r == S_ON_RUN || state_r == S_REQ_MIN) |=> !en_on && req_n_r)
      else $error("kill low did not drop enable");
   abort_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_TMR_RUN && kill_s && !trig_low |=> en_on && req_n_r)
      else $error("timer abort failed");
   gnd_hold_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_REQ_MIN && tmr_mode_r == TMR_GND && kill_s |=> en_on)
      else $error("forced off with grounded timer");
   lock_quiet_a: assert property (@(posedge CLK) disable iff (!NRST)
      state_r == S_LOCKOUT |-> !en_on && req_n_r)
      else $error("outputs active during lockout");
   good_follow_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE |=> SENSE_GOOD == $past(mon_s))
      else $error("sense good does not follow monitor");

   // Checks on turn-off timing, ignored inputs, priority and debounce restart
   req_min_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_REQ_MIN && kill_s && cnt_r < DEB_CYCLES - 32'h1 |=> !req_n_r)
      else $error("request released before its minimum width");
   open_off_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_REQ_MIN && kill_s && trig_low && tmr_mode_r == TMR_OPEN
      && cnt_r >= DEB_CYCLES - 32'h1 |=> !en_on && req_n_r)
      else $error("open timer did not force off");
   tmr_off_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_TMR_RUN && kill_s && trig_low && cnt_r >= tmr_last |=> !en_on && req_n_r)
      else $error("timer end did not force off");
   hold_wait_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_OFF_HOLD && !btn_s |=> state_r == S_OFF_HOLD)
      else $error("lockout started with button held");
   btn_ign_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_ON_RUN && ign_btn_r && !btn_s && kill_s && !mon_fall |=> state_r == S_ON_RUN)
      else $error("held button acted before release");
   mon_ign_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_ON_RUN && !src_mon_r && btn_s && kill_s |=> state_r == S_ON_RUN && req_n_r)
      else $error("monitor acted after button power-up");
   btn_first_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_WAIT && btn_fall |=> state_r == S_ON_DEB && !src_mon_r)
      else $error("button did not take priority");
   mon_start_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_WAIT && !btn_fall && mon_rise |=> state_r == S_ON_DEB && src_mon_r)
      else $error("monitor rise did not start power-up");
   deb_restart_a: assert property (@(posedge CLK) disable iff (!NRST)
      CE && state_r == S_ON_DEB && !src_mon_r && btn_s |=> cnt_r == 32'h0)
      else $error("button bounce did not restart debounce");
endmodule : pwrseq
`default_nettype wire

// File: sim/pwrseq_proc.sv
// Processor model that boots and answers a shutdown request on the kill line
`timescale 1ns/1ps
`default_nettype none
module pwrseq_proc #(
   parameter int BOOT_CYC = 12,
   parameter int KILL_CYC = 10
) (
   input  wire logic CLK,
   input  wire logic POWER_EN,
   input  wire logic SHUTDOWN_REQ_N,
   input  wire logic BOOT_OK,
   input  wire logic RESP_OK,
   output var logic  KILL_N
);
   int up_cnt;
   int req_cnt;
   initial KILL_N = 1'b0;
   // Unpowered holds kill low; a booted processor raises it, a willing one kills later
   always @(posedge CLK) begin
      up_cnt  <= POWER_EN ? up_cnt + 1 : 0;
      req_cnt <= (POWER_EN && !SHUTDOWN_REQ_N) ? req_cnt + 1 : 0;
      if (!POWER_EN)
         KILL_N <= 1'b0;
      else if (up_cnt == BOOT_CYC && BOOT_OK)
         KILL_N <= 1'b1;
      else if (req_cnt == KILL_CYC && RESP_OK)
         KILL_N <= 1'b0;
   end
endmodule : pwrseq_proc
`default_nettype wire

// File: sim/pwrseq_tb.sv
// Self-checking bench for the pushbutton power sequencer
`timescale 1ns/1ps
`default_nettype none
module pwrseq_tb;
   import pwrseq_pkg::*;
   localparam int DEB = 20, BLK = 50, LCK = 40, TST = 3;
   typedef struct { logic [32:0] val; int lo; int hi; } note_t;
   logic        clk, nrst, ce, button_n, monitor, mode_sel, boot_ok, resp_ok, kill_n;
   logic        psel, penable, pwrite, pready, pslverr, power_en, req_n, good, en_inv;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  last = 2'b01;
   logic [1:0]  modes[3] = '{TMR_OPEN, TMR_CAP, TMR_GND};
   note_t       evq[$], rdq[$];
   int          cyc = 0, n_errors = 0, total_checks = 0, off;

   pwrseq #(.DEB_CYCLES(DEB), .BLANK_CYCLES(BLK), .LOCK_CYCLES(LCK)) u_pwrseq (
      .CLK(clk), .NRST(nrst), .CE(ce), .BUTTON_N(button_n), .MONITOR(monitor), .KILL_N(kill_n),
      .MODE_SEL(mode_sel), .POWER_EN(power_en), .SHUTDOWN_REQ_N(req_n), .SENSE_GOOD(good),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
   pwrseq #(.DEB_CYCLES(DEB), .BLANK_CYCLES(BLK), .LOCK_CYCLES(LCK), .EN_ACT_LOW(1'b1)) u_pwrseq_inv (
      .CLK(clk), .NRST(nrst), .CE(ce), .BUTTON_N(button_n), .MONITOR(monitor), .KILL_N(kill_n),
      .MODE_SEL(mode_sel), .POWER_EN(en_inv), .SHUTDOWN_REQ_N(), .SENSE_GOOD(),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(), .PREADY(), .PSLVERR());
   pwrseq_proc u_pwrseq_proc (.CLK(clk), .POWER_EN(power_en), .SHUTDOWN_REQ_N(req_n),
      .BOOT_OK(boot_ok), .RESP_OK(resp_ok), .KILL_N(kill_n));

   // Clock and a cycle count read away from the rising edge
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(negedge clk) cyc++;

   task automatic results();
      $display("Checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : results

   task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt

   // Note an enable/request change due within a cycle window
   task automatic ev(input logic [1:0] v, input int lo, input int hi);
      evq.push_back('{{31'h0, v}, cyc + lo, cyc + hi});
   endtask : ev

   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge clk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (i >= 50) begin
         n_errors++;
         results();
      end else begin
         @(posedge clk);                                    // Idle edge before any next setup
      end
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [32:0] exp);
      rdq.push_back('{exp, 0, 0});
      apb(1'b0, a, 32'h0);
   endtask : rd

   // Bouncy press, then held until the enable comes up
   task automatic btn_on();
      repeat (3) begin
         button_n <= 1'b0;
         wt(5 + $urandom % 10);
         button_n <= 1'b1;
         wt(4);
      end
      button_n <= 1'b0;
      ev(2'b11, DEB, DEB + 6);
      wt(DEB + 8);
   endtask : btn_on

   task automatic press_req();
      button_n <= 1'b0;
      ev(2'b10, DEB, DEB + 6);
      wt(DEB + 6);
   endtask : press_req

   task automatic kill_off();
      resp_ok <= 1'b1;
      press_req();
      button_n <= 1'b1;
      ev(2'b01, 5, 16);
      wt(LCK + 30);
      resp_ok <= 1'b0;
   endtask : kill_off

   // Match each output change or read against the oldest note
   always @(posedge clk) begin
      note_t n;
      n = '{33'h1_ffff_ffff, 0, 0};
      if (nrst === 1'b1 && {power_en, req_n} !== last) begin
         if (evq.size() > 0) n = evq.pop_front();
         last = {power_en, req_n};
         check("enable and request", n.val, {31'h0, last});
         check("event cycle", 33'h1, {32'h0, cyc >= n.lo && cyc <= n.hi});
         check("inverted enable", {32'h0, ~power_en}, {32'h0, en_inv});
      end
      if (pready === 1'b1 && pwrite === 1'b0) begin
         if (rdq.size() > 0) n = rdq.pop_front();
         check("read data", n.val, {pslverr, prdata});
      end
      if (pready === 1'b1 && pwrite === 1'b1) check("write error", 33'h0, {32'h0, pslverr});
   end

   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      results();
   end

   initial begin
      void'($urandom(32'h7627));
      nrst = 1'b0; ce = 1'b1; button_n = 1'b1; monitor = 1'b0; mode_sel = 1'b0;
      boot_ok = 1'b1; resp_ok = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0;
      wt(20);
      nrst <= 1'b1;
      wt(LCK + 10);
      // Register reset values, unmapped place, zero step
      rd(CTRL_OFS, {1'b0, 30'h0, CTRL_RST});
      rd(TSTEP_OFS, {1'b0, TSTEP_RST});
      rd(STATUS_OFS, 33'h2);
      rd(8'h0c, 33'h1_0000_0000);
      apb(1'b1, TSTEP_OFS, 32'h0);
      rd(TSTEP_OFS, 33'h1);
      apb(1'b1, TSTEP_OFS, TST);
      rd(TSTEP_OFS, TST);
      check("sense good", 33'h0, {32'h0, good});
      // Held through blanking, then kill-driven turn-off
      btn_on();
      wt(BLK);
      button_n <= 1'b1;
      wt(10);
      kill_off();
      // Processor never boots: power drops at end of blanking
      boot_ok <= 1'b0;
      btn_on();
      button_n <= 1'b1;
      ev(2'b01, BLK - 8, BLK + 2);
      wt(BLK + LCK + 10);
      boot_ok <= 1'b1;
      // Forced turn-off for the open and capacitor timer modes; the grounded timer holds power until release
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, CTRL_OFS, {30'h0, modes[i]});
         btn_on();
         button_n <= 1'b1;
         wt(BLK);
         press_req();
         off = DEB + ((modes[i] == TMR_CAP) ? 16 * TST : 0);
         if (modes[i] == TMR_GND) begin
            wt(DEB + 16 * TST + 20);
            button_n <= 1'b1;
            ev(2'b11, 2, 8);
            wt(10);
            kill_off();
         end else begin
            ev(2'b01, off - 5, off + 4);
            wt(off + 30);
            button_n <= 1'b1;
            wt(LCK - 8);
            button_n <= 1'b0;
            wt(DEB + 10);
            button_n <= 1'b1;
            wt(10);
         end
      end
      // Abort during the timer, then early release after the request
      apb(1'b1, CTRL_OFS, {30'h0, TMR_CAP});
      btn_on();
      button_n <= 1'b1;
      wt(BLK);
      press_req();
      wt(DEB + 8);
      button_n <= 1'b1;
      ev(2'b11, 1, 6);
      wt(10);
      press_req();
      button_n <= 1'b1;
      ev(2'b11, DEB - 6, DEB + 4);
      wt(DEB + 10);
      kill_off();
      // Monitor turn-on and immediate monitor turn-off
      mode_sel <= 1'b1;
      monitor <= 1'b1;
      ev(2'b11, DEB, DEB + 7);
      wt(6);
      check("sense good", 33'h1, {32'h0, good});
      wt(DEB + BLK + 10);
      resp_ok <= 1'b1;
      monitor <= 1'b0;
      ev(2'b10, 1, 6);
      ev(2'b01, 10, 20);
      wt(LCK + 30);
      resp_ok <= 1'b0;
      // Mode select low blocks the monitor fall
      mode_sel <= 1'b0;
      monitor <= 1'b1;
      ev(2'b11, DEB, DEB + 7);
      wt(DEB + BLK + 15);
      monitor <= 1'b0;
      wt(30);
      kill_off();
      // Button power-up ignores the monitor
      mode_sel <= 1'b1;
      btn_on();
      button_n <= 1'b1;
      monitor <= 1'b1;
      wt(BLK);
      monitor <= 1'b0;
      wt(30);
      kill_off();
      // Button and monitor together: button wins
      button_n <= 1'b0;
      monitor <= 1'b1;
      ev(2'b11, DEB, DEB + 6);
      wt(DEB + 8);
      button_n <= 1'b1;
      wt(BLK + 5);
      rd(STATUS_OFS, 33'h37);
      monitor <= 1'b0;
      wt(30);
      kill_off();
      check("pending notes", 33'h0, 33'(evq.size() + rdq.size()));
      results();
   end
endmodule : pwrseq_tb
`default_nettype wire
